// ===== logic/nmn_params.svh
// Constants for the negate, multiply and no-operation execute slice
`ifndef NMN_PARAMS_SVH
`define NMN_PARAMS_SVH

// Register byte offsets on the bus
`define OFS_CTRL        8'h00
`define OFS_INSTR       8'h04
`define OFS_WORK        8'h08
`define OFS_BANK        8'h0c
`define OFS_STATUS      8'h10
`define OFS_PROD_LOW    8'h14
`define OFS_PROD_HIGH   8'h18
`define OFS_INDEX_BASE  8'h1c
`define OFS_MEM_ADDR    8'h20
`define OFS_MEM_DATA    8'h24

// Control register fields
`define CTRL_EXT_BIT    0
`define CTRL_BUSY_BIT   1

// Status register fields
`define ST_CARRY_BIT    0
`define ST_DIGIT_BIT    1
`define ST_ZERO_BIT     2
`define ST_OVF_BIT      3
`define ST_NEG_BIT      4

// Reset values
`define RST_CTRL        1'h0
`define RST_INSTR       16'h0000
`define RST_WORK        8'h00
`define RST_BANK        4'h0
`define RST_STATUS      5'h00
`define RST_PROD        8'h00
`define RST_INDEX_BASE  12'h000
`define RST_MEM_ADDR    12'h000

// Instruction encodings
`define OPC_NEGATE      7'h36
`define OPC_MULTIPLY    7'h01
`define OPC_SKIP_WORD   16'h0000
`define OPC_SKIP_TOP    4'hf

// Data address map
`define ACCESS_SPLIT    8'h60
`define INDEXED_LIMIT   8'h5f
`define SFR_PAGE        4'hf

`endif

// ===== logic/nmn_pkg.sv
// Types for the negate, multiply and no-operation execute slice
`default_nettype none
package nmn_pkg;

	typedef enum logic [3:0] {
		OP_SKIP = 4'b0001,
		OP_NEG  = 4'b0010,
		OP_MUL  = 4'b0100,
		OP_NONE = 4'b1000
	} op_t;

	typedef enum logic [4:0] {
		PH_IDLE    = 5'b00001,
		PH_DECODE  = 5'b00010,
		PH_READ    = 5'b00100,
		PH_PROCESS = 5'b01000,
		PH_WRITE   = 5'b10000
	} phase_t;

endpackage
`default_nettype wire

// ===== logic/nmn_addr_gen.sv
// Data address former for byte-oriented file operands
`timescale 1ns/10ps
`default_nettype none
`include "nmn_params.svh"

module nmn_addr_gen #(
	parameter int ADDR_W = 12
) (
	// Operand fields
	input  wire logic [7:0]        file_i,
	input  wire logic              bank_access_i,
	// Addressing state
	input  wire logic              ext_en_i,
	input  wire logic [3:0]        bank_i,
	input  wire logic [ADDR_W-1:0] index_base_i,
	// Resolved address
	output logic      [ADDR_W-1:0] addr_o
);

	always_comb begin
		if (bank_access_i) begin
			addr_o = ADDR_W'({bank_i, file_i}); // RULE_07
		end else if (ext_en_i && (file_i <= `INDEXED_LIMIT)) begin
			addr_o = index_base_i + ADDR_W'(file_i); // RULE_08
		end else if (file_i < `ACCESS_SPLIT) begin
			addr_o = ADDR_W'({4'h0, file_i}); // RULE_06
		end else begin
			addr_o = ADDR_W'({`SFR_PAGE, file_i}); // RULE_06
		end
	end

endmodule
`default_nettype wire

// ===== logic/nmn_alu.sv
// Negate and unsigned multiply datapath with status flags
`timescale 1ns/10ps
`default_nettype none

module nmn_alu (
	// Operands
	input  wire logic [7:0]  operand_i,
	input  wire logic [7:0]  work_i,
	// Negate result and flags
	output logic      [7:0]  neg_result_o,
	output logic             neg_flag_o,
	output logic             ovf_flag_o,
	output logic             carry_flag_o,
	output logic             digit_flag_o,
	output logic             zero_flag_o,
	// Product
	output logic      [15:0] product_o
);

	logic [8:0] neg_sum;
	logic [4:0] low_sum;

	always_comb begin
		neg_sum      = {1'b0, ~operand_i} + 9'h001; // RULE_03
		low_sum      = {1'b0, ~operand_i[3:0]} + 5'h01;
		neg_result_o = neg_sum[7:0];
		carry_flag_o = neg_sum[8]; // RULE_05
		digit_flag_o = low_sum[4]; // RULE_05
		ovf_flag_o   = (operand_i == 8'h80); // RULE_05
		neg_flag_o   = neg_sum[7]; // RULE_05
		zero_flag_o  = (neg_sum[7:0] == 8'h00); // RULE_05
		product_o    = 16'(work_i) * 16'(operand_i); // RULE_09
	end

endmodule
`default_nettype wire

// ===== logic/nmn_core.sv
// Execute slice for negate, multiply and no-operation behind an Avalon-MM slave
`timescale 1ns/10ps
`default_nettype none
`include "nmn_params.svh"

// Behaviour
// RULE_01: Negate takes an 8-bit file address 0..255 and one bank-access bit.
// RULE_02: Negate decodes from 0110 110a followed by eight address bits.
// RULE_03: Negate computes inverted operand plus one.
// RULE_04: Negate result goes back to the operand's memory location, not work.
// RULE_05: Negate updates negative, overflow, carry, digit-carry and zero flags.
// RULE_06: Bank-access bit zero resolves the address within the access bank.
// RULE_07: Bank-access bit one combines bank select with the file address.
// RULE_08: Extended set, bit zero, address up to 95 uses indexed literal offset.
// RULE_09: Multiply forms unsigned 16-bit work times file, sources unchanged.
// RULE_10: Multiply puts high byte in product high, low in product low.
// RULE_11: Multiply leaves every status flag unchanged, even for a zero product.
// RULE_12: Each instruction is one word, one cycle: decode, read, process, write.
// RULE_13: All-zero word or top nibble all ones is a no-operation.
module nmn_core
	import nmn_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int MEM_DEPTH = 4096
) (
	// Clock and reset
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	// Avalon-MM slave
	input  wire logic [7:0]  address_i,
	input  wire logic        read_i,
	input  wire logic        write_i,
	input  wire logic [31:0] writedata_i,
	input  wire logic [3:0]  byteenable_i,
	output logic      [31:0] readdata_o,
	output logic             waitrequest_o
);

	// Registers
	logic               ext_en_r;
	logic [15:0]        instr_r;
	logic [7:0]         work_r;
	logic [3:0]         bank_r;
	logic [4:0]         status_r;
	logic [7:0]         prod_low_r;
	logic [7:0]         prod_high_r;
	logic [ADDR_W-1:0]  index_base_r;
	logic [ADDR_W-1:0]  mem_addr_r;
	logic [7:0]         data_mem [MEM_DEPTH];

	// Execution state
	phase_t             phase_r;
	phase_t             phase_nxt;
	op_t                op_r;
	logic [ADDR_W-1:0]  exec_addr_r;
	logic [7:0]         operand_r;
	logic [7:0]         result_r;
	logic [4:0]         flags_r;
	logic [15:0]        product_r;
	logic               start_r;

	// Bus handshake
	logic               accept;
	logic               bus_write;
	logic [31:0]        read_mux;
	logic [31:0]        wr_merged;

	// Datapath wires
	logic [ADDR_W-1:0]  decoded_addr;
	logic [7:0]         neg_result;
	logic               neg_flag;
	logic               ovf_flag;
	logic               carry_flag;
	logic               digit_flag;
	logic               zero_flag;
	logic [15:0]        product;

	// Classify an instruction word
	function automatic op_t decode_op(input logic [15:0] word);
		if (word == `OPC_SKIP_WORD || word[15:12] == `OPC_SKIP_TOP) begin
			decode_op = OP_SKIP; // RULE_13
		end else if (word[15:9] == `OPC_NEGATE) begin
			decode_op = OP_NEG; // RULE_02
		end else if (word[15:9] == `OPC_MULTIPLY) begin
			decode_op = OP_MUL;
		end else begin
			decode_op = OP_NONE;
		end
	endfunction

	// Merge written byte lanes into an old value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		merge = res;
	endfunction

	// Address former for the current instruction word
	nmn_addr_gen #(
		.ADDR_W (ADDR_W)
	) nmn_addr_gen_inst (
		.file_i        (instr_r[7:0]),
		.bank_access_i (instr_r[8]),
		.ext_en_i      (ext_en_r),
		.bank_i        (bank_r),
		.index_base_i  (index_base_r),
		.addr_o        (decoded_addr)
	);

	// Arithmetic on the operand fetched in the read phase
	nmn_alu nmn_alu_inst (
		.operand_i    (operand_r),
		.work_i       (work_r),
		.neg_result_o (neg_result),
		.neg_flag_o   (neg_flag),
		.ovf_flag_o   (ovf_flag),
		.carry_flag_o (carry_flag),
		.digit_flag_o (digit_flag),
		.zero_flag_o  (zero_flag),
		.product_o    (product)
	);

	// Requests wait while an instruction runs
	always_comb begin
		accept    = (read_i || write_i) && waitrequest_o && (phase_r == PH_IDLE) && !start_r;
		bus_write = write_i && !waitrequest_o;
	end

	always_comb begin
		read_mux = 32'h0000_0000;
		case (address_i)
			`OFS_CTRL: begin
				read_mux[`CTRL_EXT_BIT] = ext_en_r;
				read_mux[`CTRL_BUSY_BIT] = (phase_r != PH_IDLE) || start_r;
			end
			`OFS_INSTR:      read_mux[15:0] = instr_r;
			`OFS_WORK:       read_mux[7:0] = work_r;
			`OFS_BANK:       read_mux[3:0] = bank_r;
			`OFS_STATUS:     read_mux[4:0] = status_r;
			`OFS_PROD_LOW:   read_mux[7:0] = prod_low_r;
			`OFS_PROD_HIGH:  read_mux[7:0] = prod_high_r;
			`OFS_INDEX_BASE: read_mux[ADDR_W-1:0] = index_base_r;
			`OFS_MEM_ADDR:   read_mux[ADDR_W-1:0] = mem_addr_r;
			`OFS_MEM_DATA:   read_mux[7:0] = data_mem[mem_addr_r];
			default:         read_mux = 32'h0000_0000;
		endcase
	end

	// Written byte lanes merged into the addressed register's value
	always_comb begin
		wr_merged = merge(read_mux, writedata_i, byteenable_i);
	end

	// Waitrequest drops for one cycle per accepted access
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			waitrequest_o <= 1'b1;
			readdata_o    <= 32'h0000_0000;
		end else begin
			waitrequest_o <= !accept;
			if (accept) begin
				readdata_o <= read_mux;
			end
		end
	end

	// Software configuration registers
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ext_en_r     <= `RST_CTRL;
			work_r       <= `RST_WORK;
			bank_r       <= `RST_BANK;
			index_base_r <= `RST_INDEX_BASE;
			mem_addr_r   <= `RST_MEM_ADDR;
		end else if (bus_write) begin
			case (address_i)
				`OFS_CTRL:       ext_en_r <= wr_merged[`CTRL_EXT_BIT];
				`OFS_WORK:       work_r <= wr_merged[7:0];
				`OFS_BANK:       bank_r <= wr_merged[3:0];
				`OFS_INDEX_BASE: index_base_r <= wr_merged[ADDR_W-1:0];
				`OFS_MEM_ADDR:   mem_addr_r <= wr_merged[ADDR_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// Instruction register; a write starts execution
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			instr_r <= `RST_INSTR;
			start_r <= 1'b0;
		end else begin
			start_r <= 1'b0;
			if (bus_write && address_i == `OFS_INSTR) begin
				instr_r <= wr_merged[15:0];
				start_r <= 1'b1;
			end
		end
	end

	// Four-phase instruction cycle
	always_comb begin
		case (phase_r)
			PH_IDLE:    phase_nxt = start_r ? PH_DECODE : PH_IDLE; // RULE_12
			PH_DECODE:  phase_nxt = PH_READ; // RULE_12
			PH_READ:    phase_nxt = PH_PROCESS; // RULE_12
			PH_PROCESS: phase_nxt = PH_WRITE; // RULE_12
			PH_WRITE:   phase_nxt = PH_IDLE; // RULE_12
			default:    phase_nxt = PH_IDLE;
		endcase
	end

	// Phase register
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			phase_r <= PH_IDLE;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	// Decode, operand read and processing
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			op_r        <= OP_SKIP;
			exec_addr_r <= '0;
			operand_r   <= 8'h00;
			result_r    <= 8'h00;
			flags_r     <= 5'h00;
			product_r   <= 16'h0000;
		end else begin
			case (phase_r)
				PH_DECODE: begin
					op_r        <= decode_op(instr_r); // RULE_13
					exec_addr_r <= decoded_addr; // RULE_01
				end
				PH_READ: begin
					if (op_r == OP_NEG || op_r == OP_MUL) begin
						operand_r <= data_mem[exec_addr_r];
					end
				end
				PH_PROCESS: begin
					result_r  <= neg_result; // RULE_03
					product_r <= product; // RULE_09
					flags_r[`ST_CARRY_BIT] <= carry_flag;
					flags_r[`ST_DIGIT_BIT] <= digit_flag;
					flags_r[`ST_ZERO_BIT]  <= zero_flag;
					flags_r[`ST_OVF_BIT]   <= ovf_flag;
					flags_r[`ST_NEG_BIT]   <= neg_flag;
				end
				default: begin
				end
			endcase
		end
	end

	// Status flags: written only by a negate or by software
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			status_r <= `RST_STATUS;
		end else if (phase_r == PH_WRITE && op_r == OP_NEG) begin
			status_r <= flags_r; // RULE_05
		end else if (phase_r == PH_WRITE && op_r == OP_MUL) begin
			status_r <= status_r; // RULE_11
		end else if (bus_write && address_i == `OFS_STATUS) begin
			status_r <= wr_merged[4:0];
		end
	end

	// Product pair: written by a multiply or by software
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			prod_low_r  <= `RST_PROD;
			prod_high_r <= `RST_PROD;
		end else if (phase_r == PH_WRITE && op_r == OP_MUL) begin
			prod_high_r <= product_r[15:8]; // RULE_10
			prod_low_r  <= product_r[7:0]; // RULE_10
		end else if (bus_write) begin
			if (address_i == `OFS_PROD_LOW) begin
				prod_low_r <= wr_merged[7:0];
			end
			if (address_i == `OFS_PROD_HIGH) begin
				prod_high_r <= wr_merged[7:0];
			end
		end
	end

	// Data memory: negate write-back or software store
	always_ff @(posedge clock_i) begin
		if (phase_r == PH_WRITE && op_r == OP_NEG) begin
			data_mem[exec_addr_r] <= result_r; // RULE_04
		end else if (bus_write && address_i == `OFS_MEM_DATA && byteenable_i[0]) begin
			data_mem[mem_addr_r] <= writedata_i[7:0];
		end
	end

endmodule
`default_nettype wire

// ===== verif/nmn_core_assertions.sv
// Bus-level assertions for the execute slice
`timescale 1ns/10ps
`default_nettype none
`include "nmn_params.svh"
module nmn_core_assertions (
	// Clock and reset
	input wire logic        clock_i,
	input wire logic        rst_i,
	// Avalon-MM slave
	input wire logic [7:0]  address_i,
	input wire logic        read_i,
	input wire logic        write_i,
	input wire logic [31:0] writedata_i,
	input wire logic [3:0]  byteenable_i,
	input wire logic [31:0] readdata_o,
	input wire logic        waitrequest_o
);
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	property p_one_low;
		!waitrequest_o |=> waitrequest_o;
	endproperty
	a_one_low: assert property (p_one_low) else $error("answer low too long");
	property p_fell_req;
		$fell(waitrequest_o) |-> $past(read_i | write_i);
	endproperty
	a_fell_req: assert property (p_fell_req) else $error("answer without request");
	property p_answer;
		(read_i | write_i) && waitrequest_o |-> ##[1:8] !waitrequest_o;
	endproperty
	a_answer: assert property (p_answer) else $error("answer late");
	property p_busy;
		write_i && address_i == `OFS_INSTR && !waitrequest_o |=> waitrequest_o [*5];
	endproperty
	a_busy: assert property (p_busy) else $error("bus free during execution");
	property p_rd_hold;
		waitrequest_o && $past(waitrequest_o) |-> $stable(readdata_o);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_unmapped;
		read_i && address_i > `OFS_MEM_DATA && !waitrequest_o |-> readdata_o == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_status_w;
		read_i && address_i == `OFS_STATUS && !waitrequest_o |-> readdata_o[31:5] == 27'h0;
	endproperty
	a_status_w: assert property (p_status_w) else $error("status upper bits set");
	property p_prod_w;
		read_i && (address_i == `OFS_PROD_LOW || address_i == `OFS_PROD_HIGH) && !waitrequest_o
			|-> readdata_o[31:8] == 24'h0;
	endproperty
	a_prod_w: assert property (p_prod_w) else $error("product upper bits set");
endmodule
bind nmn_core nmn_core_assertions nmn_core_assertions_inst (
	.clock_i(clock_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
	.writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
	.waitrequest_o(waitrequest_o));
`default_nettype wire

// ===== verif/test_nmn_core.sv
// Testbench for the execute slice
`timescale 1ns/10ps
`default_nettype none
`include "nmn_params.svh"
module test_nmn_core;
	logic        clock_i = 0;
	logic        rst_i = 1;
	logic [7:0]  address_i = 8'h0;
	logic        read_i = 0;
	logic        write_i = 0;
	logic [31:0] writedata_i = 32'h0;
	logic [3:0]  byteenable_i = 4'hf;
	logic [31:0] readdata_o;
	logic        waitrequest_o;
	logic [31:0] rd;
	int          error_cnt = 0;
	int          checks = 0;
	int          cycles = 0;
	nmn_core nmn_core_inst (.clock_i(clock_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
		.write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
		.readdata_o(readdata_o), .waitrequest_o(waitrequest_o));
	initial forever #2.5 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			error_cnt++;
			test_done();
		end
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		address_i <= a;
		writedata_i <= d;
		write_i <= wr_en;
		read_i <= !wr_en;
		@(posedge clock_i);
		while (waitrequest_o !== 1'b0) @(posedge clock_i);
		rd = readdata_o;
		read_i <= 0;
		write_i <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1, a, d);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		bus(0, a, 32'h0);
		check(rd, exp, what);
	endtask
	task automatic mem_set(input logic [11:0] a, input logic [7:0] d);
		wr(`OFS_MEM_ADDR, {20'h0, a});
		wr(`OFS_MEM_DATA, {24'h0, d});
	endtask
	task automatic mem_chk(input logic [11:0] a, input logic [7:0] d);
		wr(`OFS_MEM_ADDR, {20'h0, a});
		rdchk(`OFS_MEM_DATA, {24'h0, d}, "memory");
	endtask
	task automatic t_reset;
		logic [7:0] r[6] = '{`OFS_CTRL, `OFS_STATUS, `OFS_PROD_HIGH, `OFS_BANK, `OFS_INDEX_BASE, 8'h40};
		wr(8'h40, 32'hffffffff);
		foreach (r[i]) rdchk(r[i], 32'h0, "reset value");
		$display("reset test done");
	endtask
	task automatic t_neg;
		logic [11:0] ad[7] = '{12'h53a, 12'h010, 12'hf60, 12'h182, 12'h181, 12'hf60, 12'h500};
		logic [7:0]  fa[7] = '{8'h3a, 8'h10, 8'h60, 8'h5f, 8'h5e, 8'h60, 8'h00};
		logic [7:0]  op[7] = '{8'h3a, 8'h00, 8'h80, 8'h01, 8'hf0, 8'hff, 8'h7f};
		logic [1:0]  ea[7] = '{2'h1, 2'h0, 2'h0, 2'h2, 2'h2, 2'h2, 2'h3};
		logic [7:0]  res;
		logic [4:0]  st;
		wr(`OFS_BANK, 32'h5);
		wr(`OFS_INDEX_BASE, 32'h123);
		wr(`OFS_WORK, 32'h55);
		for (int i = 0; i < 7; i++) begin
			res = ~op[i] + 8'h1;
			st = {res[7], op[i] == 8'h80, res == 8'h0, op[i][3:0] == 4'h0, op[i] == 8'h0};
			mem_set(ad[i], op[i]);
			wr(`OFS_STATUS, {27'h0, ~st});
			wr(`OFS_CTRL, {31'h0, ea[i][1]});
			wr(`OFS_INSTR, {16'h0, `OPC_NEGATE, ea[i][0], fa[i]});
			mem_chk(ad[i], res);
			rdchk(`OFS_STATUS, {27'h0, st}, "status");
		end
		rdchk(`OFS_WORK, 32'h55, "work");
		wr(`OFS_CTRL, 32'h0);
		$display("negate test done");
	endtask
	task automatic t_mul;
		logic [7:0]  op[2] = '{8'hb5, 8'h00};
		logic [4:0]  st[2] = '{5'h1f, 5'h00};
		logic [15:0] p;
		wr(`OFS_WORK, 32'hc4);
		for (int i = 0; i < 2; i++) begin
			p = 16'hc4 * {8'h0, op[i]};
			mem_set(12'hf70, op[i]);
			wr(`OFS_STATUS, {27'h0, st[i]});
			wr(`OFS_INSTR, {16'h0, `OPC_MULTIPLY, 9'h070});
			rdchk(`OFS_PROD_LOW, {24'h0, p[7:0]}, "product low");
			rdchk(`OFS_PROD_HIGH, {24'h0, p[15:8]}, "product high");
			rdchk(`OFS_STATUS, {27'h0, st[i]}, "status");
			rdchk(`OFS_WORK, 32'hc4, "work");
			mem_chk(12'hf70, op[i]);
		end
		$display("multiply test done");
	endtask
	task automatic t_no_operation;
		logic [15:0] w[3] = '{16'h0000, 16'hffff, 16'hf6c5};
		mem_set(12'hfc5, 8'h42);
		wr(`OFS_STATUS, 32'h0a);
		wr(`OFS_PROD_LOW, 32'h33);
		foreach (w[i]) begin
			wr(`OFS_INSTR, {16'h0, w[i]});
			rdchk(`OFS_STATUS, 32'h0a, "status");
			rdchk(`OFS_PROD_LOW, 32'h33, "product low");
			mem_chk(12'hfc5, 8'h42);
		end
		$display("no-operation test done");
	endtask
	initial begin
		repeat (3) @(posedge clock_i);
		rst_i <= 0;
		t_reset();
		t_neg();
		t_mul();
		t_no_operation();
		test_done();
	end
endmodule
`default_nettype wire
